//--- flash_prog_device.sv
// Device end of the parallel flash program port: code array, locks,
// address counter and the self-timed write and erase engine.
// Assumes all pins arrive asynchronously and are synchronised here.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_device
    import flash_prog_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC_DEF,
    parameter int ERASE_CYCLES = ERASE_CYC_DEF,
    // Identification values are arbitrary.
    parameter logic [7:0] SIG_BYTE0 = 8'h5a,
    parameter logic [7:0] SIG_BYTE1 = 8'h3c,
    parameter logic [7:0] SIG_BYTE2 = 8'h00
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Programming pins
    flash_pins_if.device pins
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [15:0] meta_ff;
    logic [15:0] sync_ff;
    wire [15:0] pin_raw;

    assign pin_raw = {pins.rst_level, pins.osc_input_pin, pins.program_strobe_pin_n,
                      pins.mode_select_a, pins.mode_select_b, pins.mode_select_c,
                      pins.mode_select_d, pins.byte_data_port};

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_ff <= PIN_IDLE;
            sync_ff <= PIN_IDLE;
        end
        else
        begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
        end
    end

    wire [1:0] s_rst_lvl;
    wire s_osc;
    wire s_strobe_n;
    wire [3:0] s_mode;
    wire [7:0] s_data;

    assign s_rst_lvl = sync_ff[15:14];
    assign s_osc = sync_ff[13];
    assign s_strobe_n = sync_ff[12];
    assign s_mode = sync_ff[11:8];
    assign s_data = sync_ff[7:0];

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    logic rst_hi_d_ff;
    logic osc_d_ff;
    logic strobe_d_ff;
    wire rst_hi;
    wire rst_rise;
    wire osc_rise;
    wire strobe_rise;
    wire at_vpp;
    wire at_high;

    assign rst_hi = (s_rst_lvl != RL_LOW);
    assign rst_rise = rst_hi & ~rst_hi_d_ff;
    assign osc_rise = s_osc & ~osc_d_ff;
    assign strobe_rise = s_strobe_n & ~strobe_d_ff;
    assign at_vpp = (s_rst_lvl == RL_VPP);
    assign at_high = (s_rst_lvl == RL_HIGH);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rst_hi_d_ff <= 1'b0;
            osc_d_ff <= 1'b0;
            strobe_d_ff <= 1'b1;
        end
        else
        begin
            rst_hi_d_ff <= rst_hi;
            osc_d_ff <= s_osc;
            strobe_d_ff <= s_strobe_n;
        end
    end

    // ----------------------------------------------------------------
    // Address counter
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addr_ff;
    wire [ADDR_W-1:0] nxt_addr;

    // Stepping past the last location wraps by natural overflow.
    assign nxt_addr = rst_rise ? ADDR_RESET : (osc_rise ? addr_ff + 1'b1 : addr_ff);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            addr_ff <= ADDR_RESET;
        else
            addr_ff <= nxt_addr;
    end

    // ----------------------------------------------------------------
    // Write and erase engine
    // ----------------------------------------------------------------
    localparam logic [TMR_W-1:0] WR_LAST = TMR_W'(WRITE_CYCLES - 1);
    localparam logic [TMR_W-1:0] ER_LAST = TMR_W'(ERASE_CYCLES - 1);

    dev_state_e state_ff;
    dev_state_e nxt_state;
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;
    logic [ADDR_W-1:0] wr_addr_ff;
    logic [7:0] wr_data_ff;
    logic [3:0] wr_mode_ff;
    logic lock_wr_ff;
    logic lock_vf_ff;
    logic [7:0] mem_ff [DEPTH];

    wire write_mode;
    wire write_req;
    wire erase_req;
    wire erase_fire;
    wire write_end;
    wire commit_byte;

    assign write_mode = (s_mode == MODE_WRITE) | (s_mode == MODE_LOCK1) | (s_mode == MODE_LOCK2);
    assign write_req = (state_ff == DEV_IDLE) & at_vpp & strobe_rise & write_mode;
    assign erase_req = (state_ff == DEV_IDLE) & at_vpp & ~s_strobe_n & (s_mode == MODE_ERASE);
    assign erase_fire = erase_req & (tmr_ff == ER_LAST);
    assign write_end = (state_ff == DEV_WRITE) & (tmr_ff == WR_LAST);
    // A byte that is no longer blank, or an array under the first lock, is left alone.
    assign commit_byte = write_end & (wr_mode_ff == MODE_WRITE) & ~lock_wr_ff
                         & (mem_ff[wr_addr_ff] == ERASED_BYTE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_tmr = '0;
        case (state_ff)
            DEV_IDLE:
            begin
                if (write_req)
                    nxt_state = DEV_WRITE;
                else if (erase_fire)
                    nxt_state = DEV_ERASE;
                else if (erase_req)
                    nxt_tmr = tmr_ff + 1'b1;
            end
            DEV_WRITE:
            begin
                if (write_end)
                    nxt_state = DEV_IDLE;
                else
                    nxt_tmr = tmr_ff + 1'b1;
            end
            DEV_ERASE:
            begin
                // Wait for the strobe to return so one long pulse erases once.
                if (s_strobe_n)
                    nxt_state = DEV_IDLE;
            end
            default:
                nxt_state = DEV_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_ff <= DEV_IDLE;
            tmr_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wr_addr_ff <= ADDR_RESET;
            wr_data_ff <= ERASED_BYTE;
            wr_mode_ff <= MODE_SIG;
        end
        else if (write_req)
        begin
            wr_addr_ff <= addr_ff;
            wr_data_ff <= s_data;
            wr_mode_ff <= s_mode;
        end
    end

    // Locks only set through their own write modes and only clear on erase or system reset.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || erase_fire)
        begin
            lock_wr_ff <= 1'b0;
            lock_vf_ff <= 1'b0;
        end
        else if (write_end)
        begin
            lock_wr_ff <= lock_wr_ff | (wr_mode_ff == MODE_LOCK1);
            lock_vf_ff <= lock_vf_ff | (wr_mode_ff == MODE_LOCK2);
        end
    end

    // The array is flops, so system reset stands in for the erased shipping state.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || erase_fire)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= ERASED_BYTE;
        end
        else if (commit_byte)
            mem_ff[wr_addr_ff] <= wr_data_ff;
    end

    // ----------------------------------------------------------------
    // Readback and progress
    // ----------------------------------------------------------------
    logic [7:0] dout_ff;
    logic doe_ff;
    logic progress_ff;
    wire rd_code;
    wire rd_sig;
    wire polling;
    wire [7:0] sig_byte;
    wire [7:0] rd_byte;

    // Locks are never put on the port; only their effect is visible.
    assign rd_code = at_high & (s_mode == MODE_READ) & ~(lock_wr_ff & lock_vf_ff);
    assign rd_sig = at_high & (s_mode == MODE_SIG);
    assign sig_byte = (addr_ff == 10'h000) ? SIG_BYTE0 :
                      ((addr_ff == 10'h001) ? SIG_BYTE1 : SIG_BYTE2);
    assign polling = (state_ff == DEV_WRITE) & (wr_mode_ff == MODE_WRITE) & (addr_ff == wr_addr_ff);
    assign rd_byte = rd_sig ? sig_byte :
                     (polling ? {~wr_data_ff[7], mem_ff[addr_ff][6:0]} : mem_ff[addr_ff]);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dout_ff <= ERASED_BYTE;
            doe_ff <= 1'b0;
            progress_ff <= 1'b1;
        end
        else
        begin
            dout_ff <= rd_byte;
            doe_ff <= rd_code | rd_sig;
            progress_ff <= (nxt_state != DEV_WRITE);
        end
    end

    assign pins.dev_data_out = dout_ff;
    assign pins.dev_data_oe = doe_ff;
    assign pins.progress_out_pin = progress_ff;

endmodule
`default_nettype wire

//--- flash_prog_pkg.sv
// Constants, encodings and state types shared by the flash program port
// device end, the programmer end and the pin interface.
// Assumes a single 40 MHz system clock on both ends.
//
// Behaviour
// - Array ships erased; blank-only byte writes.
// - Address clears on reset rise, steps on osc.
// - Reset level and mode lines pick operation.
// - Programmer presents data, then raises programming level; the host enables data and raises the level in the same cycle.
// - One strobe pulse starts self-timed write.
// - Verify at logic high with read pattern.
// - Step address, new byte, repeat per location.
// - Busy read returns inverted bit seven.
// - Progress pin low after strobe, high when done.
// - Unlocked readback: clear, read, step, read.
// - First lock blocks writes, both block reads.
// - Only chip erase clears the locks; system reset here clears them too.
// - Lock state has no direct readout.
// - Erase strobe held low clears everything.
// - Identification bytes at first three locations.
// - Power-up: reset, osc low, then high levels.
// - Power-off: osc low, then reset low.
package flash_prog_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int WRITE_TIME_US = 1200;
    localparam int WRITE_MAX_US = 2000;
    localparam int WRITE_CYC_DEF = WRITE_TIME_US * CLK_MHZ;
    localparam int ERASE_TIME_MS = 10;
    localparam int ERASE_CYC_DEF = ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int VPP_SETUP_US = 10;
    localparam int SETUP_CYC = VPP_SETUP_US * CLK_MHZ;
    localparam int PROG_WIDTH_US = 2;
    localparam int PROG_CYC = PROG_WIDTH_US * CLK_MHZ;
    localparam int TMR_W = 20;

    // ----------------------------------------------------------------
    // Array
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DEPTH = 1024;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [9:0] ADDR_RESET = 10'h000;
    localparam logic [7:0] PULLUP_BYTE = 8'hff;
    localparam logic [15:0] PIN_IDLE = 16'h10ff;

    // ----------------------------------------------------------------
    // Pin encodings, mode lines packed as {a, b, c, d}
    // ----------------------------------------------------------------
    localparam logic [1:0] RL_LOW = 2'h0;
    localparam logic [1:0] RL_HIGH = 2'h1;
    localparam logic [1:0] RL_VPP = 2'h2;
    localparam logic [3:0] MODE_WRITE = 4'h7;
    localparam logic [3:0] MODE_READ = 4'h3;
    localparam logic [3:0] MODE_LOCK1 = 4'hf;
    localparam logic [3:0] MODE_LOCK2 = 4'hc;
    localparam logic [3:0] MODE_ERASE = 4'h8;
    localparam logic [3:0] MODE_SIG = 4'h0;

    // ----------------------------------------------------------------
    // Programmer commands and registers
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_ADDR_CLR = 4'h1;
    localparam logic [3:0] OP_ADDR_STEP = 4'h2;
    localparam logic [3:0] OP_WRITE = 4'h3;
    localparam logic [3:0] OP_LOCK1 = 4'h4;
    localparam logic [3:0] OP_LOCK2 = 4'h5;
    localparam logic [3:0] OP_ERASE = 4'h6;
    localparam logic [3:0] OP_READ = 4'h7;
    localparam logic [3:0] OP_SIG = 4'h8;
    localparam logic [3:0] OP_POWER_OFF = 4'h9;
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_WRITE = 2'b01,
        DEV_ERASE = 2'b11
    } dev_state_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_PULSE = 3'b011,
        H_RECOV = 3'b010,
        H_WAIT = 3'b110
    } host_state_e;

endpackage

//--- flash_pins_if.sv
// Pin bundle between the programmer and the device's programming port.
// The shared data port is resolved here; an undriven port reads as pulled up.
`timescale 1ns/1ps
`default_nettype none
interface flash_pins_if;
    import flash_prog_pkg::*;

    logic [1:0] rst_level;
    logic osc_input_pin;
    logic program_strobe_pin_n;
    logic mode_select_a;
    logic mode_select_b;
    logic mode_select_c;
    logic mode_select_d;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic [7:0] dev_data_out;
    logic dev_data_oe;
    logic progress_out_pin;
    wire [7:0] byte_data_port;

    // Device drive wins on contention so polling stays observable.
    assign byte_data_port = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : PULLUP_BYTE);

    modport device (
        input rst_level, osc_input_pin, program_strobe_pin_n,
        input mode_select_a, mode_select_b, mode_select_c, mode_select_d,
        input byte_data_port,
        output dev_data_out, dev_data_oe, progress_out_pin
    );

    modport host (
        output rst_level, osc_input_pin, program_strobe_pin_n,
        output mode_select_a, mode_select_b, mode_select_c, mode_select_d,
        output host_data_out, host_data_oe,
        input byte_data_port, progress_out_pin
    );

endinterface
`default_nettype wire

//--- flash_prog_host.sv
// Programmer end: an APB slave takes one command at a time and plays
// the pin sequence for it on the device's programming port.
// Assumes APB on clk_sys; device pins come back asynchronously.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_host
    import flash_prog_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYC_DEF
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Programming pins
    flash_pins_if.host pins
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [8:0] meta_ff;
    logic [8:0] sync_ff;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= {pins.progress_out_pin, pins.byte_data_port};
            sync_ff <= meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    localparam logic [TMR_W-1:0] SET_LAST = TMR_W'(SETUP_CYC - 1);
    localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYC - 1);
    // Hold erase past the device's threshold to cover its input delay.
    localparam logic [TMR_W-1:0] ERASE_LAST = TMR_W'(ERASE_CYCLES + SETUP_CYC - 1);

    host_state_e state_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [3:0] op_ff;
    logic [7:0] wdat_ff;
    logic [7:0] rdat_ff;
    logic [1:0] rst_lvl_ff;
    logic osc_ff;
    logic strobe_n_ff;
    logic [3:0] mode_ff;
    logic hoe_ff;

    wire go;
    wire prog_op;
    wire [3:0] op_mode;
    wire [TMR_W-1:0] pulse_last;
    wire tmr_done;

    assign prog_op = (op_ff == OP_WRITE) | (op_ff == OP_LOCK1) | (op_ff == OP_LOCK2) | (op_ff == OP_ERASE);
    assign op_mode = (op_ff == OP_WRITE) ? MODE_WRITE :
                     (op_ff == OP_LOCK1) ? MODE_LOCK1 :
                     (op_ff == OP_LOCK2) ? MODE_LOCK2 :
                     (op_ff == OP_ERASE) ? MODE_ERASE :
                     (op_ff == OP_READ) ? MODE_READ :
                     (op_ff == OP_SIG) ? MODE_SIG : mode_ff;
    assign pulse_last = (op_ff == OP_ERASE) ? ERASE_LAST : (prog_op ? PROG_LAST : '0);
    assign tmr_done = (state_ff == H_PULSE) ? (tmr_ff == pulse_last) : (tmr_ff == SET_LAST);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_ff <= H_IDLE;
            tmr_ff <= '0;
            rdat_ff <= ERASED_BYTE;
            rst_lvl_ff <= RL_LOW;
            osc_ff <= 1'b0;
            strobe_n_ff <= 1'b1;
            mode_ff <= MODE_SIG;
            hoe_ff <= 1'b0;
        end
        else
        begin
            tmr_ff <= tmr_ff + 1'b1;
            case (state_ff)
                H_IDLE:
                begin
                    tmr_ff <= '0;
                    if (go)
                        state_ff <= H_SETUP;
                end
                H_SETUP:
                begin
                    mode_ff <= op_mode;
                    osc_ff <= 1'b0;
                    if (prog_op)
                    begin
                        rst_lvl_ff <= RL_VPP;
                        hoe_ff <= (op_ff == OP_WRITE);
                    end
                    else if (op_ff == OP_READ || op_ff == OP_SIG)
                        rst_lvl_ff <= RL_HIGH;
                    else if (op_ff == OP_ADDR_CLR)
                        rst_lvl_ff <= RL_LOW;
                    if (tmr_done)
                    begin
                        tmr_ff <= '0;
                        state_ff <= H_PULSE;
                    end
                end
                H_PULSE:
                begin
                    strobe_n_ff <= ~prog_op;
                    osc_ff <= (op_ff == OP_ADDR_STEP);
                    if (op_ff == OP_ADDR_CLR)
                        rst_lvl_ff <= RL_HIGH;
                    else if (op_ff == OP_POWER_OFF)
                        rst_lvl_ff <= RL_LOW;
                    if (tmr_done)
                    begin
                        tmr_ff <= '0;
                        state_ff <= H_RECOV;
                    end
                end
                H_RECOV:
                begin
                    strobe_n_ff <= 1'b1;
                    osc_ff <= 1'b0;
                    if (tmr_done)
                        state_ff <= H_WAIT;
                end
                H_WAIT:
                begin
                    // Busy is low here only for a write or lock whose cycle outlasts recovery; wait for progress high.
                    if (sync_ff[8])
                    begin
                        state_ff <= H_IDLE;
                        hoe_ff <= 1'b0;
                        rdat_ff <= sync_ff[7:0];
                        if (prog_op)
                            rst_lvl_ff <= RL_HIGH;
                    end
                end
                default:
                    state_ff <= H_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // APB registers
    // ----------------------------------------------------------------
    logic [31:0] prdata_ff;
    logic pready_ff;
    wire apb_fire;
    wire [31:0] rd_val;

    assign apb_fire = psel & penable & pready_ff;
    // Commands written while a sequence runs are dropped; poll busy first.
    assign go = apb_fire & pwrite & (paddr == CMD_OFS) & (state_ff == H_IDLE);
    assign rd_val = (paddr == CMD_OFS) ? {16'h0000, wdat_ff, 4'h0, op_ff} :
                    (paddr == STAT_OFS) ? {16'h0000, rdat_ff, 6'h00, sync_ff[8], state_ff != H_IDLE} :
                    32'h0000_0000;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= '0;
            op_ff <= 4'h0;
            wdat_ff <= 8'h00;
        end
        else
        begin
            pready_ff <= psel & penable & ~pready_ff;
            prdata_ff <= rd_val;
            if (go)
            begin
                op_ff <= pwdata[3:0];
                wdat_ff <= pwdata[15:8];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = 1'b0;
    assign pins.rst_level = rst_lvl_ff;
    assign pins.osc_input_pin = osc_ff;
    assign pins.program_strobe_pin_n = strobe_n_ff;
    assign pins.mode_select_a = mode_ff[3];
    assign pins.mode_select_b = mode_ff[2];
    assign pins.mode_select_c = mode_ff[1];
    assign pins.mode_select_d = mode_ff[0];
    assign pins.host_data_out = wdat_ff;
    assign pins.host_data_oe = hoe_ff;

endmodule
`default_nettype wire

//--- flash_prog_properties.sv
// Checker on the pins between the two ends.
// Assumes it sits beside the pin interface on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_properties
    import flash_prog_pkg::*;
#(
    parameter int WRITE_CYCLES = 50
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins
    input wire logic [1:0] rst_level,
    input wire logic osc_input_pin,
    input wire logic program_strobe_pin_n,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic mode_select_c,
    input wire logic mode_select_d,
    input wire logic dev_data_oe,
    input wire logic progress_out_pin
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Slack covers the pin synchronisers on both ends.
    localparam int WR_MAX = WRITE_CYCLES + 8;
    wire [3:0] mode_w = {mode_select_a, mode_select_b, mode_select_c, mode_select_d};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence busy_start_s;
        $fell(progress_out_pin);
    endsequence
    strobe_at_vpp_a: assert property ($fell(program_strobe_pin_n) |-> rst_level == RL_VPP)
        else $error("strobe low outside programming");
    strobe_width_a: assert property ($fell(program_strobe_pin_n) |-> !program_strobe_pin_n [*8])
        else $error("strobe pulse too short");
    busy_at_vpp_a: assert property (!progress_out_pin |-> rst_level == RL_VPP)
        else $error("busy shown outside programming");
    busy_min_a: assert property (busy_start_s |-> !progress_out_pin [*8])
        else $error("busy pulse too short");
    busy_max_a: assert property (busy_start_s |-> ##[1:WR_MAX] progress_out_pin)
        else $error("write cycle too long");
    oe_at_high_a: assert property ($rose(dev_data_oe) |-> rst_level == RL_HIGH)
        else $error("port driven outside verify");
    erase_quiet_a: assert property ((rst_level == RL_VPP && mode_w == MODE_ERASE) |-> progress_out_pin)
        else $error("busy shown during erase");
    osc_pulse_a: assert property ($rose(osc_input_pin) |=> !osc_input_pin)
        else $error("step pulse too long");
endmodule
`default_nettype wire

//--- parallel_flash_program_port_bench.sv
// Bench: APB orders to the programmer end, pins on to the device.
// Assumes the model of array, locks and counter below.
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_program_port_bench;
    import flash_prog_pkg::*;
    // Identification values are arbitrary.
    localparam logic [7:0] SIG0 = 8'h6b;
    localparam logic [7:0] SIG1 = 8'h29;
    localparam logic [7:0] SIG2 = 8'h00;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr;
    int failures = 0, cmp_count = 0, addr = 0;
    int seed = 32'h8b32;
    int mem [1024];
    bit l1 = 0, l2 = 0, low = 1;
    always #12.5 clk_sys = ~clk_sys;
    flash_pins_if pins ();
    flash_prog_device #(.WRITE_CYCLES(50), .ERASE_CYCLES(100), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
        .SIG_BYTE2(SIG2)) u_flash_prog_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins));
    flash_prog_host #(.ERASE_CYCLES(100)) u_flash_prog_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins));
    flash_prog_properties #(.WRITE_CYCLES(50)) u_flash_prog_properties (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .rst_level(pins.rst_level), .osc_input_pin(pins.osc_input_pin),
        .program_strobe_pin_n(pins.program_strobe_pin_n), .mode_select_a(pins.mode_select_a),
        .mode_select_b(pins.mode_select_b), .mode_select_c(pins.mode_select_c),
        .mode_select_d(pins.mode_select_d), .dev_data_oe(pins.dev_data_oe),
        .progress_out_pin(pins.progress_out_pin));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task conclude(input int extra);
        failures += extra;
        $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
            conclude(1);
    endtask
    // Expectations come from the model, never from the design.
    task op(input logic [3:0] o, input logic [7:0] d = 8'h00);
        int n;
        logic [7:0] e;
        n = 0;
        e = 8'hff;
        if (low)
            addr = 0;
        low = (o == OP_POWER_OFF);
        case (o)
            OP_ADDR_CLR: addr = 0;
            OP_ADDR_STEP: addr = (addr + 1) % 1024;
            OP_WRITE: if (!l1 && mem[addr] == 255) mem[addr] = d;
            OP_LOCK1: l1 = 1;
            OP_LOCK2: l2 = 1;
            OP_ERASE:
            begin
                foreach (mem[i])
                    mem[i] = 255;
                l1 = 0;
                l2 = 0;
            end
            OP_READ: e = (l1 && l2) ? 8'hff : mem[addr][7:0];
            OP_SIG: e = (addr == 0) ? SIG0 : ((addr == 1) ? SIG1 : SIG2);
        endcase
        apb(1'b1, CMD_OFS, {16'h0, d, 4'h0, o});
        do
        begin
            apb(1'b0, STAT_OFS);
            n++;
        end
        while (r[0] !== 1'b0 && n < 600);
        if (n >= 600)
            conclude(1);
        if (o == OP_READ || o == OP_SIG)
            chk("read byte", {24'h0, e}, {24'h0, r[15:8]});
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        foreach (mem[i])
            mem[i] = 255;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, STAT_OFS);
        chk("status", 32'h0000ff02, r);
        apb(1'b0, 8'h3c);
        chk("unmapped", 32'h0, r);
        op(OP_READ);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            op(OP_WRITE, 8'($random(seed)));
            op(OP_READ);
            op(OP_ADDR_STEP);
        end
        op(OP_ADDR_CLR);
        for (int i = 0; i < 4; i++)
        begin
            op(OP_READ);
            op(OP_ADDR_STEP);
        end
        op(OP_ADDR_CLR);
        op(OP_WRITE, 8'h00);
        op(OP_READ);
        $display("test program done");
        for (int i = 0; i < 4; i++)
        begin
            op(OP_SIG);
            op(OP_ADDR_STEP);
        end
        $display("test signature done");
        op(OP_LOCK1);
        op(OP_WRITE, 8'($random(seed)));
        op(OP_READ);
        op(OP_ADDR_CLR);
        op(OP_LOCK2);
        op(OP_READ);
        op(OP_SIG);
        $display("test locks done");
        op(OP_ERASE);
        op(OP_READ);
        op(OP_WRITE, 8'($random(seed)));
        op(OP_READ);
        $display("test erase done");
        op(OP_ADDR_STEP);
        op(OP_POWER_OFF);
        op(OP_READ);
        $display("test power cycle done");
        conclude(0);
    end
endmodule
`default_nettype wire
